// ---- common/mrm_pkg.sv ----
package mrm_pkg;

   typedef struct packed {
      logic wr;
      logic [3:0] grp;
      logic [15:0] addr;
      logic [31:0] wdata;
   } mrm_req_t;

   typedef enum logic [1:0] {
      MRM_L_IDLE = 2'b01,
      MRM_L_WAIT = 2'b10
   } mrm_link_st_t;

endpackage

// ---- common/mrm_regs.svh ----
// Behaviour
// - sample boot strap at every reset
// - strap low boots normal, pins live
// - strap high isolates pins until cleared
// - irq and register access work while isolated
// - decode groups 0,1,2,3,4,12 by width
// - group selector plus 16-bit address per access
// - 16-bit groups read upper bytes as zero
// - 16-bit writes drop upper two bytes
// - reset loads every field default
// - plain field returns last written value
// - sticky field locks after designated value
// - read-only fields ignore writes, constants fixed
// - clear-on-read field clears after read
// - any write clears clear-on-any-write field
// - value-qualified clear needs designated bit value
// - writable field clears after being read
// - trigger field reverts when operation completes
// - latch-one field holds until read
// - latch-zero field holds until read
`ifndef MRM_REGS_SVH
`define MRM_REGS_SVH

// group selectors
`define MRM_GRP_SPI 4'h0
`define MRM_GRP_MAC 4'h1
`define MRM_GRP_PCS 4'h2
`define MRM_GRP_PMA 4'h3
`define MRM_GRP_VMMD 4'h4
`define MRM_GRP_VEND 4'hC

// offsets inside group 0
`define MRM_ADR_IDENT 16'h0000
`define MRM_ADR_CFG 16'h0004
`define MRM_ADR_STS 16'h0008
`define MRM_ADR_CMD 16'h0010
`define MRM_ADR_ISO 16'h0014
// offset inside group 12
`define MRM_ADR_SCRATCH 16'h0000

// field positions
`define MRM_CFG_LOCK_BIT 16
`define MRM_STS_LH_BIT 0
`define MRM_STS_LL_BIT 1
`define MRM_STS_CW_BIT 2
`define MRM_STS_CV1_BIT 3
`define MRM_STS_CV0_BIT 4
`define MRM_STS_CNT_LSB 8
`define MRM_CMD_TRIG_BIT 0
`define MRM_CMD_SCR_BIT 1
`define MRM_ISO_BIT 0

// reset values
`define MRM_CFG_RST 16'h0000
`define MRM_SCRATCH_RST 16'h0000
`define MRM_IDENT_VAL 32'h0000_0A5C

`endif

// ---- rtl/mrm_regmap.sv ----
`timescale 1ns/1ps
`include "mrm_regs.svh"

module mrm_regmap
   import mrm_pkg::*;
#(
   parameter int PIN_W = 8,
   parameter int EV_W = 6,
   // arbitrary identification value
   parameter logic [31:0] IDENT = `MRM_IDENT_VAL
)
(
   // core clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // boot strap pin
   input wire logic boot_strap_pin_in,
   // link side, on link clock
   input wire logic link_clk_in,
   input wire logic req_valid_in,
   input wire mrm_req_t req_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output logic [31:0] rsp_rdata_out,
   // device events and operation handshake
   input wire logic [EV_W-1:0] events_in,
   input wire logic op_done_in,
   output logic op_start_out,
   output logic boot_isolated_out,
   // interface pins
   input wire logic [PIN_W-1:0] pin_data_in,
   input wire logic [PIN_W-1:0] pin_oe_in,
   output logic [PIN_W-1:0] pin_data_out,
   output logic [PIN_W-1:0] pin_oe_out,
   // interrupt request
   input wire logic irq_in,
   output logic irq_n_out
);

   if (PIN_W < 1 || EV_W != 6)
   begin
      $error("mrm_regmap: PIN_W must be >= 1 and EV_W must be 6");
   end

   // ==========================================================
   // link domain reset and request holding
   logic lrst_s1_q, lrst_s2_q;
   mrm_link_st_t lst_q;
   mrm_req_t hold_q;
   logic req_tgl_q;
   logic ack_s1_q, ack_s2_q, ack_s3_q;
   logic ack_tgl_q;
   logic [31:0] core_rdata_q;

   always_ff @(posedge link_clk_in)
   begin
      lrst_s1_q <= sys_rst_in;
      lrst_s2_q <= lrst_s1_q;
   end

   always_ff @(posedge link_clk_in)
   begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
   end

   assign req_ready_out = (lst_q == MRM_L_IDLE);

   always_ff @(posedge link_clk_in)
   begin
      if (lrst_s2_q)
      begin
         lst_q <= MRM_L_IDLE;
         req_tgl_q <= 1'b0;
         hold_q <= '0;
         rsp_valid_out <= 1'b0;
         rsp_rdata_out <= 32'h0000_0000;
      end
      else
      begin
         rsp_valid_out <= 1'b0;
         case (lst_q)
            MRM_L_IDLE:
            begin
               if (req_valid_in)
               begin
                  hold_q <= req_in;
                  req_tgl_q <= ~req_tgl_q;
                  lst_q <= MRM_L_WAIT;
               end
            end
            MRM_L_WAIT:
            begin
               if (ack_s2_q != ack_s3_q)
               begin
                  rsp_valid_out <= 1'b1;
                  rsp_rdata_out <= core_rdata_q;
                  lst_q <= MRM_L_IDLE;
               end
            end
            default:
            begin
               lst_q <= MRM_L_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // core side request detection
   logic req_s1_q, req_s2_q, req_s3_q;
   logic go;
   logic rd_go, wr_go;
   logic g0, g12, wide, grp_ok;
   logic [31:0] wd;
   logic [31:0] rd_val;

   always_ff @(posedge clk_in)
   begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
   end

   assign go = req_s2_q ^ req_s3_q;
   assign rd_go = go & ~hold_q.wr;
   assign wr_go = go & hold_q.wr;
   assign g0 = (hold_q.grp == `MRM_GRP_SPI);
   assign g12 = (hold_q.grp == `MRM_GRP_VEND);
   assign wide = g0 | (hold_q.grp == `MRM_GRP_MAC);
   assign grp_ok = wide | g12 | (hold_q.grp == `MRM_GRP_PCS)
      | (hold_q.grp == `MRM_GRP_PMA) | (hold_q.grp == `MRM_GRP_VMMD);
   assign wd = wide ? hold_q.wdata : {16'h0000, hold_q.wdata[15:0]};

   logic hit_cfg, hit_sts, hit_cmd, hit_iso, hit_scr;
   assign hit_cfg = g0 & (hold_q.addr == `MRM_ADR_CFG);
   assign hit_sts = g0 & (hold_q.addr == `MRM_ADR_STS);
   assign hit_cmd = g0 & (hold_q.addr == `MRM_ADR_CMD);
   assign hit_iso = g0 & (hold_q.addr == `MRM_ADR_ISO);
   assign hit_scr = g12 & (hold_q.addr == `MRM_ADR_SCRATCH);

   // ==========================================================
   // boot strap and isolation
   logic strap_s1_q, strap_s2_q;
   logic strap_q;
   logic iso_q;

   always_ff @(posedge clk_in)
   begin
      strap_s1_q <= boot_strap_pin_in;
      strap_s2_q <= strap_s1_q;
   end

   // strap caught on every cycle of reset, so its release value wins
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         strap_q <= strap_s2_q;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         iso_q <= strap_s2_q;
      end
      else if (wr_go && hit_iso && !wd[`MRM_ISO_BIT])
      begin
         iso_q <= 1'b0;
      end
   end

   assign boot_isolated_out = iso_q;

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         pin_data_out <= '0;
         pin_oe_out <= '0;
         irq_n_out <= 1'b1;
      end
      else
      begin
         pin_data_out <= pin_data_in;
         pin_oe_out <= iso_q ? '0 : pin_oe_in;
         irq_n_out <= ~irq_in;
      end
   end

   // ==========================================================
   // field storage
   logic [15:0] cfg_q;
   logic lock_q;
   logic lh_q, ll_q, cw_q, cv1_q, cv0_q;
   logic [3:0] cnt_q;
   logic trig_q, scr_q;
   logic [15:0] scratch_q;

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         cfg_q <= `MRM_CFG_RST;
         scratch_q <= `MRM_SCRATCH_RST;
      end
      else
      begin
         if (wr_go && hit_cfg)
         begin
            cfg_q <= wd[15:0];
         end
         if (wr_go && hit_scr)
         begin
            scratch_q <= wd[15:0];
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         lock_q <= 1'b0;
      end
      else if (wr_go && hit_cfg && wd[`MRM_CFG_LOCK_BIT])
      begin
         lock_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         lh_q <= 1'b0;
         ll_q <= 1'b1;
         cnt_q <= 4'h0;
      end
      else
      begin
         if (events_in[0])
            lh_q <= 1'b1;
         else if (rd_go && hit_sts)
            lh_q <= 1'b0;
         if (events_in[1])
            ll_q <= 1'b0;
         else if (rd_go && hit_sts)
            ll_q <= 1'b1;
         if (rd_go && hit_sts)
            cnt_q <= {3'b000, events_in[5]};
         else if (events_in[5] && cnt_q != 4'hF)
            cnt_q <= cnt_q + 4'h1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         cw_q <= 1'b0;
         cv1_q <= 1'b0;
         cv0_q <= 1'b0;
      end
      else
      begin
         if (events_in[2])
            cw_q <= 1'b1;
         else if (wr_go && hit_sts)
            cw_q <= 1'b0;
         if (events_in[3])
            cv1_q <= 1'b1;
         else if (wr_go && hit_sts && wd[`MRM_STS_CV1_BIT])
            cv1_q <= 1'b0;
         if (events_in[4])
            cv0_q <= 1'b1;
         else if (wr_go && hit_sts && !wd[`MRM_STS_CV0_BIT])
            cv0_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         trig_q <= 1'b0;
         scr_q <= 1'b0;
      end
      else
      begin
         if (wr_go && hit_cmd && wd[`MRM_CMD_TRIG_BIT])
         begin
            trig_q <= 1'b1;
         end
         else if (op_done_in)
         begin
            trig_q <= 1'b0;
         end
         if (wr_go && hit_cmd)
         begin
            scr_q <= wd[`MRM_CMD_SCR_BIT];
         end
         else if (rd_go && hit_cmd)
         begin
            scr_q <= 1'b0;
         end
      end
   end

   assign op_start_out = trig_q;

   // ==========================================================
   // read mux and answer
   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (hit_cfg)
         rd_val = {15'h0000, lock_q, cfg_q};
      else if (hit_sts)
         rd_val = {20'h0_0000, cnt_q, 3'b000, cv0_q, cv1_q, cw_q, ll_q, lh_q};
      else if (hit_cmd)
         rd_val = {30'h0000_0000, scr_q, trig_q};
      else if (hit_iso)
         rd_val = {31'h0000_0000, iso_q};
      else if (g0 && hold_q.addr == `MRM_ADR_IDENT)
         rd_val = IDENT;
      else if (hit_scr)
         rd_val = {16'h0000, scratch_q};
      if (!wide || !grp_ok)
         rd_val[31:16] = 16'h0000;
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         core_rdata_q <= 32'h0000_0000;
         ack_tgl_q <= 1'b0;
      end
      else if (go)
      begin
         core_rdata_q <= hold_q.wr ? 32'h0000_0000 : rd_val;
         ack_tgl_q <= ~ack_tgl_q;
      end
   end

   // ==========================================================
   // checks
   AST_ISO_HIZ: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      iso_q |=> pin_oe_out == '0)
      else $error("pins driven while isolated");
   AST_NORMAL_PASS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !iso_q |=> pin_oe_out == $past(pin_oe_in))
      else $error("pin enable not passed in normal mode");
   AST_IRQ_LIVE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      1'b1 |=> irq_n_out == !$past(irq_in))
      else $error("irq not forwarded");
   AST_STRAP: assert property (@(posedge clk_in)
      $fell(sys_rst_in) |-> iso_q == strap_q)
      else $error("boot mode not taken from strap");
   AST_HALF_UPPER: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (rd_go && !wide) |=> core_rdata_q[31:16] == 16'h0000)
      else $error("16-bit group upper bytes not zero");
   AST_STICKY: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      lock_q |=> lock_q [*4])
      else $error("sticky field released");
   AST_COR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (rd_go && hit_sts && !events_in[5]) |=> cnt_q == 4'h0)
      else $error("counter not cleared by read");
   AST_SET_WINS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (rd_go && hit_sts && events_in[0]) |=> lh_q)
      else $error("event lost during read clear");
   AST_LL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      events_in[1] |=> !ll_q)
      else $error("latch-zero field missed event");
   AST_TRIG: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (op_done_in && !wr_go) |=> !op_start_out)
      else $error("trigger not reverted on completion");
   AST_RESV: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (rd_go && !grp_ok) |=> core_rdata_q == 32'h0000_0000)
      else $error("unmapped read not zero");

endmodule

// ---- tb/mrm_host_model.sv ----
`timescale 1ns/1ps

module mrm_host_model
   import mrm_pkg::*;
(
   // link side
   input wire logic link_clk_in,
   input wire logic req_ready_in,
   input wire logic rsp_valid_in,
   input wire logic [31:0] rsp_rdata_in,
   output logic req_valid_out,
   output mrm_req_t req_out
);
   // ========================================
   // host access, held until taken
   initial
   begin
      req_valid_out = 1'b0;
      req_out = '0;
   end

   task automatic access(input logic w, input logic [3:0] g, input logic [15:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge link_clk_in);
      req_valid_out <= 1'b1;
      req_out <= '{w, g, a, wd};
      @(posedge link_clk_in);
      while (req_ready_in !== 1'b1 && n < 100)
      begin
         @(posedge link_clk_in);
         n++;
      end
      req_valid_out <= 1'b0;
      // released bus shows no stale value
      req_out <= ~req_out;
      while (rsp_valid_in !== 1'b1 && n < 100)
      begin
         @(posedge link_clk_in);
         n++;
      end
      rd = (n < 100) ? rsp_rdata_in : 32'hxxxx_xxxx;
   endtask
endmodule

// ---- tb/tb_macphy_boot_and_register_map.sv ----
`timescale 1ns/1ps
`include "mrm_regs.svh"

module tb_macphy_boot_and_register_map
   import mrm_pkg::*;
;
   logic clk_in = 1'b0;
   logic link_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic boot_strap_pin_in = 1'b0;
   logic req_valid_in;
   mrm_req_t req_in;
   logic req_ready_out;
   logic rsp_valid_out;
   logic [31:0] rsp_rdata_out;
   logic [5:0] events_in = 6'h00;
   logic op_done_in = 1'b0;
   logic op_start_out;
   logic boot_isolated_out;
   logic [7:0] pin_data_in = 8'hA5;
   logic [7:0] pin_oe_in = 8'hFF;
   logic [7:0] pin_data_out;
   logic [7:0] pin_oe_out;
   logic irq_in = 1'b0;
   logic irq_n_out;
   int mismatches = 0;
   int comparisons = 0;

   always #25 clk_in = ~clk_in;
   initial
   begin
      #3.1;
      forever #6 link_clk_in = ~link_clk_in;
   end

   mrm_regmap mrm_regmap_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .boot_strap_pin_in(boot_strap_pin_in), .link_clk_in(link_clk_in),
      .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
      .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .events_in(events_in),
      .op_done_in(op_done_in), .op_start_out(op_start_out),
      .boot_isolated_out(boot_isolated_out), .pin_data_in(pin_data_in),
      .pin_oe_in(pin_oe_in), .pin_data_out(pin_data_out), .pin_oe_out(pin_oe_out),
      .irq_in(irq_in), .irq_n_out(irq_n_out));

   mrm_host_model mrm_host_model_inst (.link_clk_in(link_clk_in),
      .req_ready_in(req_ready_out), .rsp_valid_in(rsp_valid_out),
      .rsp_rdata_in(rsp_rdata_out), .req_valid_out(req_valid_in), .req_out(req_in));

   // ========================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [3:0] g, input logic [15:0] a, input logic [31:0] e);
      logic [31:0] d;
      mrm_host_model_inst.access(1'b0, g, a, 32'h0000_0000, d);
      chk(d, e);
   endtask

   task automatic wr(input logic [3:0] g, input logic [15:0] a, input logic [31:0] v);
      logic [31:0] d;
      mrm_host_model_inst.access(1'b1, g, a, v, d);
      chk(d, 32'h0000_0000);
   endtask

   task automatic clks(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic do_reset(input logic strap);
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      boot_strap_pin_in <= strap;
      clks(6);
      sys_rst_in <= 1'b0;
      clks(4);
   endtask

   // ========================================
   // scenarios
   task automatic t_normal;
      do_reset(1'b0);
      chk(boot_isolated_out, 32'h0000_0000);
      chk(pin_oe_out, 32'h0000_00FF);
      chk(pin_data_out, 32'h0000_00A5);
      rd(`MRM_GRP_SPI, `MRM_ADR_IDENT, `MRM_IDENT_VAL);
      wr(`MRM_GRP_SPI, `MRM_ADR_IDENT, 32'hFFFF_FFFF);
      rd(`MRM_GRP_SPI, `MRM_ADR_IDENT, `MRM_IDENT_VAL);
      rd(`MRM_GRP_SPI, `MRM_ADR_CFG, 32'h0000_0000);
   endtask

   task automatic t_isolated;
      do_reset(1'b1);
      chk(boot_isolated_out, 32'h0000_0001);
      chk(pin_oe_out, 32'h0000_0000);
      irq_in <= 1'b1;
      clks(3);
      chk(irq_n_out, 32'h0000_0000);
      irq_in <= 1'b0;
      clks(3);
      chk(irq_n_out, 32'h0000_0001);
      rd(`MRM_GRP_SPI, `MRM_ADR_ISO, 32'h0000_0001);
      wr(`MRM_GRP_SPI, `MRM_ADR_ISO, 32'h0000_0001);
      clks(3);
      chk(pin_oe_out, 32'h0000_0000);
      wr(`MRM_GRP_SPI, `MRM_ADR_ISO, 32'h0000_0000);
      clks(3);
      chk(pin_oe_out, 32'h0000_00FF);
      chk(boot_isolated_out, 32'h0000_0000);
   endtask

   task automatic t_fields;
      wr(`MRM_GRP_SPI, `MRM_ADR_CFG, 32'h0001_1234);
      rd(`MRM_GRP_SPI, `MRM_ADR_CFG, 32'h0001_1234);
      wr(`MRM_GRP_SPI, `MRM_ADR_CFG, 32'h0000_5678);
      rd(`MRM_GRP_SPI, `MRM_ADR_CFG, 32'h0001_5678);
      wr(`MRM_GRP_VEND, `MRM_ADR_SCRATCH, 32'hFFFF_ABCD);
      rd(`MRM_GRP_VEND, `MRM_ADR_SCRATCH, 32'h0000_ABCD);
      rd(`MRM_GRP_MAC, 16'h0000, 32'h0000_0000);
      rd(4'h5, 16'h0000, 32'h0000_0000);
      wr(`MRM_GRP_SPI, 16'h000C, 32'hFFFF_FFFF);
      rd(`MRM_GRP_SPI, 16'h000C, 32'h0000_0000);
      do_reset(1'b0);
      rd(`MRM_GRP_SPI, `MRM_ADR_CFG, 32'h0000_0000);
      rd(`MRM_GRP_VEND, `MRM_ADR_SCRATCH, 32'h0000_0000);
   endtask

   task automatic t_status;
      @(posedge clk_in);
      events_in <= 6'h3F;
      @(posedge clk_in);
      events_in <= 6'h00;
      clks(2);
      rd(`MRM_GRP_SPI, `MRM_ADR_STS, 32'h0000_011D);
      rd(`MRM_GRP_SPI, `MRM_ADR_STS, 32'h0000_001E);
      wr(`MRM_GRP_SPI, `MRM_ADR_STS, 32'h0000_0010);
      rd(`MRM_GRP_SPI, `MRM_ADR_STS, 32'h0000_001A);
      wr(`MRM_GRP_SPI, `MRM_ADR_STS, 32'h0000_0008);
      rd(`MRM_GRP_SPI, `MRM_ADR_STS, 32'h0000_0002);
      @(posedge clk_in);
      events_in <= 6'h03;
      rd(`MRM_GRP_SPI, `MRM_ADR_STS, 32'h0000_0001);
      @(posedge clk_in);
      events_in <= 6'h00;
      rd(`MRM_GRP_SPI, `MRM_ADR_STS, 32'h0000_0001);
      rd(`MRM_GRP_SPI, `MRM_ADR_STS, 32'h0000_0002);
   endtask

   task automatic t_trigger;
      wr(`MRM_GRP_SPI, `MRM_ADR_CMD, 32'h0000_0003);
      clks(2);
      chk(op_start_out, 32'h0000_0001);
      rd(`MRM_GRP_SPI, `MRM_ADR_CMD, 32'h0000_0003);
      rd(`MRM_GRP_SPI, `MRM_ADR_CMD, 32'h0000_0001);
      @(posedge clk_in);
      op_done_in <= 1'b1;
      @(posedge clk_in);
      op_done_in <= 1'b0;
      clks(2);
      chk(op_start_out, 32'h0000_0000);
      rd(`MRM_GRP_SPI, `MRM_ADR_CMD, 32'h0000_0000);
   endtask

   // ========================================
   // verdict
   task automatic conclude;
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      t_normal();
      t_isolated();
      t_fields();
      t_status();
      t_trigger();
      conclude();
   end

   initial
   begin
      #200us;
      mismatches++;
      conclude();
   end
endmodule
